// file: core/hbc_ctrl.sv
/*
 * Output control of a two-leg bridge driver: input mapping, fault priority,
 * current-limit cycle, standby and active open-load checks, short latching.
 * Assumes all inputs are synchronous to sys_clk_i; comparators are outside.
 */
`timescale 1ns/10ps
`include "hbc_defs.svh"

// Behaviour
// - Half-bridge direct: input A drives A, B drives B.
// - H-bridge direct: input A direction, B is PWM.
// - SPI mode uses virtual inputs instead of pins.
// - Active recirculation; never both transistors of one leg.
// - Half-bridge: no current limit, open load, OV action.
// - Half-bridge shorts shut down each output separately.
// - H-bridge fault priority: ground short, OT, OV, supply short, OC ordering.
// - Enable, disable pin, gate bit each force off, except while the standby open-load test runs.
// - Half-bridge priority: enable, disable, UV, gate, OT.
// - Selectable edge rate with fast bypass setting.
// - Four current thresholds; over limit sets overcurrent flag.
// - Blanking, then high-side recirculation for twice decay.
// - Decay measured until below limit, held as long again, then release gates.
// - Temperature warning stretches blanking eight times, latched.
// - On ignored above limit; off acts and resets.
// - Standby open-load test only in H-bridge, in or leaving standby.
// - Test starts leaving standby or on check-bit rise.
// - Stage one: both low sides on, shorts active.
// - Stage two: pull-up on A, sample, then restore.
// - Active open load: H-bridge, switching, no overshoot.
// - Active result held; cleared on load seen or leaving.
// - Filtered short switches off, latches until fault clear.
module hbc_ctrl
    import hbc_pkg::*;
#(
    parameter int CW = `HBC_CNT_W,
    parameter int BLANK_CYC = `HBC_BLANK_US * `HBC_CLK_MHZ,
    parameter int WARN_BLANK_CYC = `HBC_BLANK_US * `HBC_WARN_MULT * `HBC_CLK_MHZ,
    parameter int SC_FILT_CYC =
        (`HBC_SC_FILT_NS * `HBC_CLK_MHZ + `HBC_NS_PER_US - 1) / `HBC_NS_PER_US,
    parameter int OL_DISCH_CYC = `HBC_OL_DISCH_US * `HBC_CLK_MHZ,
    parameter int OL_FILT_CYC = `HBC_OL_FILT_US * `HBC_CLK_MHZ
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic direct_input_a_i,
    input wire logic direct_input_b_i,
    input wire logic virtual_input_a_i,
    input wire logic virtual_input_b_i,
    input wire logic spi_mode_i,
    input wire logic half_bridge_i,
    input wire logic master_output_pin_i,
    input wire logic output_kill_pin_i,
    input wire logic out_gate_en_i,
    input wire logic overheat_fault_i,
    input wire logic heat_warning_i,
    input wire logic supply_high_fault_i,
    input wire logic supply_low_fault_i,
    input wire logic over_limit_i,
    input wire logic short_low_a_det_i,
    input wire logic short_low_b_det_i,
    input wire logic short_high_a_det_i,
    input wire logic short_high_b_det_i,
    input wire logic fault_clear_i,
    input wire logic idle_state_i,
    input wire logic load_check_request_i,
    input wire logic pin_a_above_i,
    input wire logic overshoot_threshold_hit_i,
    input wire logic [2:0] slew_sel_i,
    input wire logic [1:0] current_cap_sel_i,
    output logic high_a_o,
    output logic low_a_o,
    output logic high_b_o,
    output logic low_b_o,
    output logic pullup_a_o,
    output logic [2:0] slew_sel_o,
    output logic slew_bypass_o,
    output logic [1:0] current_cap_sel_o,
    output logic overcurrent_flag_o,
    output logic short_low_a_o,
    output logic short_low_b_o,
    output logic short_high_a_o,
    output logic short_high_b_o,
    output logic open_load_o,
    output logic supply_high_warn_o,
    output logic limit_active_o,
    output hbc_src_t dominant_src_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    hbc_cl_t cl_st_ff, nxt_cl;
    hbc_ol_t ol_st_ff, nxt_ol;
    hbc_src_t dom;
    logic [CW-1:0] meas_cnt_ff, blank_cyc_ff, blank_len_ff;
    logic [CW-1:0] sc_cnt_ff [4];
    logic sc_flag_ff [4];
    logic oc_flag_ff, ol_idle_state_ff, ol_act_ff, win_ff, seen_ff;
    logic idle_prev_ff, lcr_prev_ff;
    logic cl_zero, ol_zero;

    // Short filtering and latching, one lane per comparator
    wire [3:0] sc_det = {short_high_b_det_i, short_high_a_det_i,
                         short_low_b_det_i, short_low_a_det_i};
    generate
        for (genvar g = 0; g < 4; g++) begin : g_sc
            wire hit = sc_det[g] && (sc_cnt_ff[g] == CW'(SC_FILT_CYC - 1));
            always_ff @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    sc_cnt_ff[g] <= '0;
                    sc_flag_ff[g] <= 1'b0;
                end else begin
                    sc_cnt_ff[g] <= (sc_det[g] && !hit) ? sc_cnt_ff[g] + 1'b1 : '0;
                    sc_flag_ff[g] <= hit | (sc_flag_ff[g] & ~fault_clear_i);
                end
            end
        end
    endgenerate
    wire sc_a = sc_flag_ff[0] | sc_flag_ff[2];
    wire sc_b = sc_flag_ff[1] | sc_flag_ff[3];
    wire sc_gnd = sc_flag_ff[0] | sc_flag_ff[1];
    wire sc_pwr = sc_flag_ff[2] | sc_flag_ff[3];
    wire sc_any = sc_a | sc_b;

    // Input selection and leg commands
    wire in_a = spi_mode_i ? virtual_input_a_i : direct_input_a_i;
    wire in_b = spi_mode_i ? virtual_input_b_i : direct_input_b_i;
    wire hb_a_high = half_bridge_i ? in_a : (in_b & in_a);
    wire hb_b_high = half_bridge_i ? in_b : (in_b & ~in_a);

    // Disable sources and priority resolution
    wire off_master_output_pin = ~master_output_pin_i;
    wire off_dis = output_kill_pin_i;
    wire off_en = ~out_gate_en_i;
    wire oc_act = (cl_st_ff != CL_IDLE);
    assign dom = off_master_output_pin ? SRC_MASTER_OUTPUT_PIN : off_dis ? SRC_DIS :
                 supply_low_fault_i ? SRC_UV : off_en ? SRC_EN :
                 half_bridge_i ? (overheat_fault_i ? SRC_OT : sc_any ? SRC_SC : SRC_NONE) :
                 sc_gnd ? SRC_SC : overheat_fault_i ? SRC_OT :
                 supply_high_fault_i ? SRC_OV : sc_pwr ? SRC_SC :
                 oc_act ? SRC_OC : SRC_NONE;

    wire ol_run = (ol_st_ff != OL_IDLE);
    wire recirc = (cl_st_ff == CL_MEAS) | (cl_st_ff == CL_HOLD);
    wire force_off = (dom inside {SRC_MASTER_OUTPUT_PIN, SRC_DIS, SRC_UV, SRC_EN, SRC_OT}) |
                     (~half_bridge_i & dom == SRC_SC) | idle_state_i;
    wire brake = ~half_bridge_i & ((dom == SRC_OV) | (recirc & in_b & dom == SRC_OC));
    wire kill_a = force_off | (half_bridge_i & sc_a);
    wire kill_b = force_off | (half_bridge_i & sc_b);
    // In H-bridge mode an on command is not honoured while the current is still above the limit
    wire block_on = ~half_bridge_i & over_limit_i & ~(high_a_o | high_b_o) &
                    (cl_st_ff == CL_IDLE);
    wire drv_a = hb_a_high & ~block_on;
    wire drv_b = hb_b_high & ~block_on;
    // High and low of a leg come from exclusive terms, so the two transistors never overlap
    wire nxt_high_a = ~ol_run & ~kill_a & (brake | drv_a);
    wire nxt_low_a = ol_run ? (ol_st_ff == OL_DISCH) : (~kill_a & ~brake & ~drv_a);
    wire nxt_high_b = ~ol_run & ~kill_b & (brake | drv_b);
    wire nxt_low_b = ol_run | (~kill_b & ~brake & ~drv_b);

    // Current-limit cycle
    wire cl_start = ~half_bridge_i & ~idle_state_i & in_b & over_limit_i & ~sc_any &
                    (high_a_o | high_b_o);
    wire cl_abort = half_bridge_i | idle_state_i | ~in_b | sc_any;
    wire [CW-1:0] blank_len = heat_warning_i ? CW'(WARN_BLANK_CYC) : CW'(BLANK_CYC);
    wire cl_load = ((cl_st_ff == CL_IDLE) & (nxt_cl == CL_BLANK)) |
                   ((cl_st_ff == CL_MEAS) & (nxt_cl == CL_HOLD));
    wire [CW-1:0] cl_load_val = (cl_st_ff == CL_IDLE) ? blank_len - 1'b1 : meas_cnt_ff;
    wire [CW-1:0] nxt_meas = (cl_st_ff != CL_MEAS) ? '0 :
                             (&meas_cnt_ff) ? meas_cnt_ff : meas_cnt_ff + 1'b1;

    always_comb begin
        nxt_cl = cl_st_ff;
        unique case (cl_st_ff)
            CL_IDLE: if (cl_start) nxt_cl = CL_BLANK;
            CL_BLANK: begin
                if (cl_abort) nxt_cl = CL_IDLE;
                else if (cl_zero) nxt_cl = CL_MEAS;
            end
            CL_MEAS: begin
                if (cl_abort) nxt_cl = CL_IDLE;
                else if (!over_limit_i) nxt_cl = CL_HOLD;
            end
            CL_HOLD: if (cl_abort || cl_zero) nxt_cl = CL_IDLE;
        endcase
    end

    hbc_timer #(.W(CW)) u_cl_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(cl_load),
        .load_val_i(cl_load_val),
        .zero_o(cl_zero)
    );

    // Standby open-load test
    wire ol_start = ~half_bridge_i & load_check_request_i & ~ol_run & ~sc_any &
                    ((idle_prev_ff & ~idle_state_i) | (idle_state_i & ~lcr_prev_ff));
    wire ol_load = ol_start | ((ol_st_ff == OL_DISCH) & (nxt_ol == OL_PULL));
    wire [CW-1:0] ol_load_val = ol_start ? CW'(OL_DISCH_CYC - 1) : CW'(OL_FILT_CYC - 1);
    wire ol_latch = (ol_st_ff == OL_PULL) & ol_zero & ~sc_any;
    wire nxt_ol_idle_state = (ol_latch & pin_a_above_i) | (ol_idle_state_ff & ~fault_clear_i);

    always_comb begin
        nxt_ol = ol_st_ff;
        unique case (ol_st_ff)
            OL_IDLE: if (ol_start) nxt_ol = OL_DISCH;
            OL_DISCH: begin
                if (sc_any) nxt_ol = OL_IDLE;
                else if (ol_zero) nxt_ol = OL_PULL;
            end
            OL_PULL: if (sc_any || ol_zero) nxt_ol = OL_IDLE;
            default: nxt_ol = OL_IDLE;
        endcase
    end

    hbc_timer #(.W(CW)) u_ol_tmr (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .load_i(ol_load),
        .load_val_i(ol_load_val),
        .zero_o(ol_zero)
    );

    // Active open-load window: a low side is off while the bridge drives
    wire act_en = ~half_bridge_i & ~idle_state_i & ~ol_run;
    wire win = act_en & ~(low_a_o & low_b_o) & (high_a_o | high_b_o);
    wire nxt_seen = win & (seen_ff | overshoot_threshold_hit_i);
    wire nxt_ol_act = ~act_en ? 1'b0 : (win_ff & ~win) ? ~seen_ff : ol_act_ff;
    wire nxt_oc = (over_limit_i & ~half_bridge_i & ~idle_state_i) |
                  (oc_flag_ff & ~fault_clear_i);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cl_st_ff <= CL_IDLE;
            ol_st_ff <= OL_IDLE;
            meas_cnt_ff <= '0;
            oc_flag_ff <= 1'b0;
            ol_idle_state_ff <= 1'b0;
            ol_act_ff <= 1'b0;
            win_ff <= 1'b0;
            seen_ff <= 1'b0;
            idle_prev_ff <= 1'b0;
            lcr_prev_ff <= 1'b0;
        end else begin
            cl_st_ff <= nxt_cl;
            ol_st_ff <= nxt_ol;
            meas_cnt_ff <= nxt_meas;
            oc_flag_ff <= nxt_oc;
            ol_idle_state_ff <= nxt_ol_idle_state;
            ol_act_ff <= nxt_ol_act;
            win_ff <= win;
            seen_ff <= nxt_seen;
            idle_prev_ff <= idle_state_i;
            lcr_prev_ff <= load_check_request_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            high_a_o <= 1'b0;
            low_a_o <= 1'b0;
            high_b_o <= 1'b0;
            low_b_o <= 1'b0;
            pullup_a_o <= 1'b0;
            slew_sel_o <= '0;
            slew_bypass_o <= 1'b0;
            current_cap_sel_o <= '0;
            open_load_o <= 1'b0;
            supply_high_warn_o <= 1'b0;
            limit_active_o <= 1'b0;
            dominant_src_o <= SRC_NONE;
        end else begin
            high_a_o <= nxt_high_a;
            low_a_o <= nxt_low_a;
            high_b_o <= nxt_high_b;
            low_b_o <= nxt_low_b;
            pullup_a_o <= (ol_st_ff == OL_PULL); // Same stage timing as the leg commands
            slew_sel_o <= slew_sel_i;
            slew_bypass_o <= (slew_sel_i == `HBC_SLEW_BYPASS);
            current_cap_sel_o <= current_cap_sel_i;
            open_load_o <= nxt_ol_idle_state | nxt_ol_act;
            supply_high_warn_o <= supply_high_fault_i;
            limit_active_o <= (nxt_cl != CL_IDLE);
            dominant_src_o <= dom;
        end
    end

    assign overcurrent_flag_o = oc_flag_ff;
    assign short_low_a_o = sc_flag_ff[0];
    assign short_low_b_o = sc_flag_ff[1];
    assign short_high_a_o = sc_flag_ff[2];
    assign short_high_b_o = sc_flag_ff[3];

    // Checks
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            blank_cyc_ff <= '0;
            blank_len_ff <= '0;
        end else begin
            blank_cyc_ff <= (cl_st_ff == CL_BLANK) ? blank_cyc_ff + 1'b1 : '0;
            if (cl_load && cl_st_ff == CL_IDLE) blank_len_ff <= blank_len;
        end
    end
    wire quiet = (dom == SRC_NONE) & ~idle_state_i & ~ol_run & ~sc_any;

    sequence s_disch_end;
        ol_st_ff == OL_DISCH && nxt_ol == OL_PULL;
    endsequence
    sequence s_pull_drive;
        pullup_a_o && !low_a_o && low_b_o && !high_a_o && !high_b_o;
    endsequence

    a_leg_exclusive: assert property (
        !(high_a_o && low_a_o) && !(high_b_o && low_b_o))
        else $error("both transistors of a leg on");
    a_half_map: assert property (
        half_bridge_i && !spi_mode_i && quiet |=> high_a_o == $past(direct_input_a_i))
        else $error("half-bridge output A not following input A");
    a_hbridge_dir: assert property (
        !half_bridge_i && !spi_mode_i && quiet && !over_limit_i |=>
        high_a_o == $past(direct_input_a_i && direct_input_b_i))
        else $error("H-bridge leg A not from direction and PWM");
    a_spi_map: assert property (
        half_bridge_i && spi_mode_i && quiet |=> high_b_o == $past(virtual_input_b_i))
        else $error("virtual input B not steering output B");
    a_half_no_limit: assert property (
        half_bridge_i |-> !brake ##1 cl_st_ff == CL_IDLE)
        else $error("limit or braking active in half-bridge");
    a_half_sc_split: assert property (
        half_bridge_i && sc_a && !sc_b && dom == SRC_SC && !idle_state_i && !ol_run |=>
        !high_a_o && !low_a_o && (high_b_o || low_b_o))
        else $error("short on A disturbed output B");
    a_hb_prio: assert property (
        !half_bridge_i && sc_gnd && overheat_fault_i && !off_master_output_pin && !off_dis &&
        !supply_low_fault_i && !off_en |=> dominant_src_o == SRC_SC)
        else $error("short to ground did not dominate overtemperature");
    a_master_output_pin_off: assert property (
        off_master_output_pin |=> !high_a_o && !low_a_o && !high_b_o && !low_b_o &&
        dominant_src_o == SRC_MASTER_OUTPUT_PIN)
        else $error("enable pin did not force outputs off");
    a_half_prio: assert property (
        half_bridge_i && !off_master_output_pin && off_dis |=> dominant_src_o == SRC_DIS)
        else $error("disable pin not dominant in half-bridge");
    a_half_both_sc: assert property (
        half_bridge_i && sc_a && sc_b && !ol_run |=>
        !high_a_o && !low_a_o && !high_b_o && !low_b_o)
        else $error("shorts on both outputs left one on");
    a_slew_bypass: assert property (
        ##1 slew_bypass_o == ($past(slew_sel_i) == `HBC_SLEW_BYPASS))
        else $error("bypass edge rate decode wrong");
    a_oc_flag: assert property (
        over_limit_i && !half_bridge_i && !idle_state_i |=> overcurrent_flag_o ##1
        (overcurrent_flag_o || $past(fault_clear_i)))
        else $error("overcurrent flag not set or dropped");
    a_blank_len: assert property (
        cl_st_ff == CL_BLANK && nxt_cl == CL_MEAS |-> blank_cyc_ff == blank_len_ff - 1'b1)
        else $error("blanking interval has wrong length");
    a_recirc_hs: assert property (
        cl_st_ff == CL_MEAS && dom == SRC_OC && in_b && !idle_state_i && !ol_run |=>
        high_a_o && high_b_o && !low_a_o && !low_b_o)
        else $error("no high-side recirculation after blanking");
    a_hold_from_meas: assert property (
        cl_st_ff == CL_MEAS && nxt_cl == CL_HOLD |=> cl_st_ff == CL_HOLD &&
        !cl_zero == ($past(meas_cnt_ff) != '0))
        else $error("hold time not taken from decay time");
    a_off_resets: assert property (
        cl_st_ff != CL_IDLE && !in_b |=> cl_st_ff == CL_IDLE)
        else $error("off command did not reset the limit cycle");
    a_ol_start: assert property (
        ol_start |=> ol_st_ff == OL_DISCH ##1 (low_a_o && low_b_o) or
        ##1 (ol_st_ff == OL_IDLE && $past(sc_any)))
        else $error("standby test did not start with discharge");
    a_ol_half: assert property (
        half_bridge_i && ol_st_ff == OL_IDLE |=> ol_st_ff == OL_IDLE)
        else $error("standby test started in half-bridge");
    a_ol_stages: assert property (
        s_disch_end |=> ol_st_ff == OL_PULL ##1 s_pull_drive)
        else $error("second test stage drive wrong");
    a_act_ol_clear: assert property (
        !act_en |=> !ol_act_ff)
        else $error("active open load kept outside normal operation");
    a_act_ol_set: assert property (
        act_en && win_ff && !win && !seen_ff |=> ol_act_ff)
        else $error("missing overshoot not flagged as open load");
    a_sc_filter: assert property (
        $rose(sc_flag_ff[0]) |-> $past(sc_cnt_ff[0]) == CW'(SC_FILT_CYC - 1))
        else $error("short flag set before filter time");
endmodule // hbc_ctrl

// file: core/hbc_defs.svh
/*
 * Timing and encoding constants for the bridge output control block.
 * Assumes a 125 MHz system clock; all times are converted to cycles by the hbc_ctrl parameter defaults.
 */
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH

`define HBC_CLK_MHZ 125
`define HBC_NS_PER_US 1000
`define HBC_BLANK_US 32
`define HBC_WARN_MULT 8
`define HBC_SC_FILT_NS 2000
`define HBC_OL_DISCH_US 100
`define HBC_OL_FILT_US 200
`define HBC_CNT_W 16
`define HBC_SLEW_BYPASS 3'h0

`endif

// file: core/hbc_pkg.sv
/*
 * Types shared by the bridge output control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hbc_pkg;
    typedef enum logic [1:0] {CL_IDLE, CL_BLANK, CL_MEAS, CL_HOLD} hbc_cl_t;
    typedef enum logic [1:0] {OL_IDLE, OL_DISCH, OL_PULL} hbc_ol_t;
    typedef enum logic [3:0] {
        SRC_NONE, SRC_MASTER_OUTPUT_PIN, SRC_DIS, SRC_UV, SRC_EN, SRC_SC, SRC_OT, SRC_OV, SRC_OC
    } hbc_src_t;
endpackage

// file: core/hbc_timer.sv
/*
 * Loadable down counter used for blanking, recirculation hold and test stages.
 * Assumes the caller loads the wanted cycle count minus one.
 */
`timescale 1ns/10ps
module hbc_timer #(
    parameter int W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic zero_o
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    assign nxt_cnt = load_i ? load_val_i : (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    assign zero_o = (cnt_ff == '0);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    a_timer_step: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!load_i && cnt_ff != '0) |=> cnt_ff == $past(cnt_ff) - 1'b1)
        else $error("timer did not count down by one");
endmodule // hbc_timer

// file: sim/hbc_host.sv
/* Host model: drives the pins and SPI settings of the bridge control.
   Assumes the bench calls its tasks; every change lands on a falling edge. */
`timescale 1ns/10ps
module hbc_host (
    input wire logic sys_clk_i,
    output logic [16:0] ctl_o
);
    initial ctl_o = 17'h04140;
    task drive(input logic [16:0] v);
        @(negedge sys_clk_i);
        ctl_o = v;
    endtask
    // Enter standby with the check bit low, then raise it
    task load_check();
        drive((ctl_o | 17'h00200) & ~17'h00400);
        drive(ctl_o | 17'h00400);
    endtask
    task clear_faults();
        drive(ctl_o | 17'h00800);
        drive(ctl_o & ~17'h00800);
    endtask
endmodule // hbc_host

// file: sim/tb_hbc_ctrl.sv
/* Self-checking bench of the bridge output control.
   Assumes hbc_host drives host pins; fault comparators come from here. */
`timescale 1ns/10ps
module tb_hbc_ctrl;
    import hbc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ot = 1'b0, warn = 1'b0, ovf = 1'b0, uvf = 1'b0, lim = 1'b0, above = 1'b0;
    logic [3:0] sc = 4'h0;
    logic shot = 1'b0;
    logic [16:0] ctl;
    logic hi_a, lo_a, hi_b, lo_b, pull, bypass, ocf, ol, ovw, lact;
    logic [3:0] scf;
    logic [2:0] slew;
    logic [1:0] cap;
    logic [31:0] r;
    hbc_src_t src;
    wire logic [3:0] g = {hi_a, lo_a, hi_b, lo_b};
    int errors = 0, checked = 0, cycles = 0;
    integer seed = 32'hcdf47462;
    hbc_host i_hbc_host (.sys_clk_i(sys_clk_i), .ctl_o(ctl));
    hbc_ctrl #(.SC_FILT_CYC(8), .BLANK_CYC(10), .WARN_BLANK_CYC(80),
        .OL_DISCH_CYC(20), .OL_FILT_CYC(30)) i_hbc_ctrl (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .direct_input_a_i(ctl[0]), .direct_input_b_i(ctl[1]),
        .virtual_input_a_i(ctl[2]), .virtual_input_b_i(ctl[3]),
        .spi_mode_i(ctl[4]), .half_bridge_i(ctl[5]),
        .master_output_pin_i(ctl[6]), .output_kill_pin_i(ctl[7]),
        .out_gate_en_i(ctl[8]), .overheat_fault_i(ot), .heat_warning_i(warn),
        .supply_high_fault_i(ovf), .supply_low_fault_i(uvf), .over_limit_i(lim),
        .short_low_a_det_i(sc[0]), .short_low_b_det_i(sc[1]),
        .short_high_a_det_i(sc[2]), .short_high_b_det_i(sc[3]),
        .fault_clear_i(ctl[11]), .idle_state_i(ctl[9]), .load_check_request_i(ctl[10]),
        .pin_a_above_i(above), .overshoot_threshold_hit_i(shot),
        .slew_sel_i(ctl[14:12]), .current_cap_sel_i(ctl[16:15]),
        .high_a_o(hi_a), .low_a_o(lo_a), .high_b_o(hi_b), .low_b_o(lo_b),
        .pullup_a_o(pull), .slew_sel_o(slew), .slew_bypass_o(bypass),
        .current_cap_sel_o(cap), .overcurrent_flag_o(ocf),
        .short_low_a_o(scf[0]), .short_low_b_o(scf[1]),
        .short_high_a_o(scf[2]), .short_high_b_o(scf[3]),
        .open_load_o(ol), .supply_high_warn_o(ovw), .limit_active_o(lact),
        .dominant_src_o(src));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    function automatic logic [3:0] gates(input logic a, input logic b, input logic half);
        if (half) return {a, ~a, b, ~b};
        return {a & b, ~(a & b), ~a & b, ~(~a & b)};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task close_out();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        step(16);
        rst_b_i = 1'b1;
        step(2);
        repeat (60) begin
            r = $random(seed);
            i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, r[5:0]});
            step(1);
            chk(g, r[4] ? gates(r[2], r[3], r[5]) : gates(r[0], r[1], r[5]));
            chk((hi_a & lo_a) | (hi_b & lo_b), 0);
        end
        // Disables beat an overheat; the pin beats the kill pin
        ot = 1'b1;
        for (int k = 0; k < 3; k++) begin
            i_hbc_host.drive({2'h0, 3'h4, 3'h0, k == 0 ? 3'h6 : k == 1 ? 3'h7 : 3'h1, 6'h23});
            step(1);
            chk(g, 0);
            chk(src, k == 0 ? SRC_MASTER_OUTPUT_PIN : k == 1 ? SRC_DIS : SRC_EN);
        end
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h23});
        step(1);
        chk({g, src}, {4'h0, SRC_OT});
        uvf = 1'b1;
        step(2);
        chk({g, src}, {4'h0, SRC_UV});
        {ot, uvf, ovf} = 3'b001;
        step(2);
        chk({g, ovw}, 5'h15);
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h03});
        step(1);
        chk({g, src}, {4'ha, SRC_OV});
        ovf = 1'b0;
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h23});
        for (int k = 0; k < 4; k++) begin
            sc = 4'h1 << k;
            step(12);
            chk(scf, sc);
            chk(g, k % 2 == 0 ? 4'h2 : 4'h8);
            sc = 4'h0;
            i_hbc_host.clear_faults();
            step(1);
            chk({scf, g}, 8'h0a);
        end
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h03});
        {warn, lim} = 2'b11;
        step(2);
        chk({lact, ocf}, 2'h3);
        step(15);
        chk(g, 4'h9);
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h01});
        step(1);
        chk({lact, g}, 5'h05);
        i_hbc_host.drive({2'h0, 3'h4, 3'h0, 3'h5, 6'h03});
        step(1);
        chk(hi_a, 0);
        {warn, lim} = 2'b00;
        step(2);
        chk(g, 4'h9);
        lim = 1'b1;
        step(14);
        chk(g, 4'ha);
        step(5);
        lim = 1'b0;
        step(3);
        chk(g, 4'ha);
        step(12);
        chk({lact, g}, 5'h09);
        i_hbc_host.clear_faults();
        step(1);
        chk(ocf, 0);
        above = 1'b1;
        i_hbc_host.load_check();
        step(5);
        chk({lo_a, lo_b, pull}, 3'h6);
        step(30);
        chk({lo_a, lo_b, pull}, 3'h3);
        step(25);
        chk({ol, pull}, 2'h2);
        i_hbc_host.clear_faults();
        step(1);
        chk(ol, 0);
        for (int k = 0; k < 8; k++) begin
            i_hbc_host.drive({k[1:0], k[2:0], ctl[11:0]});
            step(1);
            chk({bypass, slew, cap}, {k == 0, k[2:0], k[1:0]});
        end
        // Leave standby with the check bit set, then run the active check
        above = 1'b0;
        i_hbc_host.drive(ctl & ~17'h00200);
        step(5);
        chk({lo_a, lo_b, pull}, 3'h6);
        step(50);
        chk({ol, pull, g}, 6'h09);
        i_hbc_host.drive({ctl[16:2], 2'b01});
        step(3);
        chk(ol, 1);
        i_hbc_host.drive({ctl[16:2], 2'b11});
        shot = 1'b1;
        step(3);
        chk(ol, 1);
        shot = 1'b0;
        i_hbc_host.drive({ctl[16:2], 2'b01});
        step(3);
        chk(ol, 0);
        close_out();
    end
endmodule // tb_hbc_ctrl
